// File: rtl/fsbl_defs.svh
// constants for the flash lock/status host controller
// assumes a 40 MHz system clock and a 16-bit asynchronous flash bus
`ifndef FSBL_DEFS_SVH
`define FSBL_DEFS_SVH

// clock and flash bus timing
`define FSBL_CLK_NS 25
`define FSBL_T_WE_NS 60
`define FSBL_T_RD_NS 90
`define FSBL_CYC(ns) (((ns) + `FSBL_CLK_NS - 1) / `FSBL_CLK_NS)
`define FSBL_WE_CYC `FSBL_CYC(`FSBL_T_WE_NS)
`define FSBL_RD_CYC `FSBL_CYC(`FSBL_T_RD_NS)

// widths
`define FSBL_AW 22
`define FSBL_DW 16

// apb register offsets
`define FSBL_REG_CMD 8'h00
`define FSBL_REG_ADDR 8'h04
`define FSBL_REG_CTRL 8'h08
`define FSBL_REG_STAT 8'h0C
`define FSBL_REG_DATA 8'h10

// control bits
`define FSBL_CTRL_WP 0
`define FSBL_CTRL_POLL 1

// status word bits
`define FSBL_SW_READY 7
`define FSBL_SW_EPAUSE 6
`define FSBL_SW_EFAIL 5
`define FSBL_SW_PFAIL 4
`define FSBL_SW_SUPPLY 3
`define FSBL_SW_PPAUSE 2
`define FSBL_SW_LOCKED 1
`define FSBL_SW_RSVD 0
`define FSBL_SW_MASK 8'hFE

// flash command codes
`define FSBL_C_LOCK_SETUP 8'h60
`define FSBL_C_LOCK 8'h01
`define FSBL_C_UNLOCK 8'hD0
`define FSBL_C_LOCKDOWN 8'h2F
`define FSBL_C_READ_ID 8'h90
`define FSBL_C_READ_ARRAY 8'hFF
`define FSBL_C_READ_STATUS 8'h70
`define FSBL_C_CLEAR_STATUS 8'h50

// offset of the lock word inside a block in identifier mode
`define FSBL_LOCK_OFS 22'h000002

// step kinds
`define FSBL_K_END 2'h0
`define FSBL_K_WR 2'h1
`define FSBL_K_RD 2'h2

`endif

// File: rtl/fsbl_pkg.sv
// types for the flash lock/status host controller
// assumes fsbl_defs.svh supplies every numeric constant
package fsbl_pkg;

  typedef enum logic [2:0] {
    OP_LOCK,
    OP_UNLOCK,
    OP_LOCKDOWN,
    OP_READ_LOCK,
    OP_READ_STATUS,
    OP_CLEAR_STATUS,
    OP_RAW
  } fsbl_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WR_SET,
    ST_WR_LOW,
    ST_WR_HOLD,
    ST_RD_LOW,
    ST_RD_END
  } fsbl_state_t;

endpackage : fsbl_pkg

// File: rtl/fsbl_ctrl.sv
// host controller driving a flash device's lock and status commands
// assumes an apb master on the system clock and a flash on the async pins
`timescale 1ns/100ps
`include "fsbl_defs.svh"

module fsbl_ctrl (
  input wire logic i_sys_clk,                  // 40 MHz system clock
  input wire logic i_rst_n,                    // async reset, active low
  input wire logic i_psel,                     // apb select
  input wire logic i_penable,                  // apb access phase
  input wire logic i_pwrite,                   // apb write
  input wire logic [7:0] i_paddr,              // apb byte address
  input wire logic [31:0] i_pwdata,            // apb write data
  output logic [31:0] o_prdata,                // apb read data
  output logic o_pready,                       // apb ready, always one
  output logic o_pslverr,                      // apb error
  output logic [`FSBL_AW-1:0] o_fl_addr,       // flash address
  output logic [`FSBL_DW-1:0] o_fl_dq,         // flash data out
  output logic o_fl_dq_oe_n,                   // low while driving data
  input wire logic [`FSBL_DW-1:0] i_fl_dq,     // flash data in
  output logic o_fl_ce_n,                      // flash chip enable
  output logic o_fl_we_n,                      // flash write enable
  output logic o_fl_oe_n,                      // flash output enable
  output logic o_fl_wp                         // write-protect level
);

  // step table: kind in [9:8], command code in [7:0]
  function automatic logic [9:0] step_of(input fsbl_pkg::fsbl_op_t op,
                                         input logic [1:0] idx,
                                         input logic [7:0] raw);
    logic [7:0] confirm;
    confirm = `FSBL_C_LOCK;
    if (op == fsbl_pkg::OP_UNLOCK)
      confirm = `FSBL_C_UNLOCK;
    if (op == fsbl_pkg::OP_LOCKDOWN)
      confirm = `FSBL_C_LOCKDOWN;
    step_of = {`FSBL_K_END, 8'h00};
    case (op)
      fsbl_pkg::OP_LOCK, fsbl_pkg::OP_UNLOCK, fsbl_pkg::OP_LOCKDOWN:
      begin
        // two-cycle lock sequence, then status read to catch a sequence error
        case (idx)
          2'h0: step_of = {`FSBL_K_WR, `FSBL_C_LOCK_SETUP};
          2'h1: step_of = {`FSBL_K_WR, confirm};
          2'h2: step_of = {`FSBL_K_WR, `FSBL_C_READ_STATUS};
          default: step_of = {`FSBL_K_RD, 8'h00};
        endcase
      end
      fsbl_pkg::OP_READ_LOCK:
      begin
        case (idx)
          2'h0: step_of = {`FSBL_K_WR, `FSBL_C_READ_ID};
          2'h1: step_of = {`FSBL_K_RD, 8'h00};
          2'h2: step_of = {`FSBL_K_WR, `FSBL_C_READ_ARRAY};
          default: step_of = {`FSBL_K_END, 8'h00};
        endcase
      end
      fsbl_pkg::OP_READ_STATUS:
      begin
        if (idx == 2'h0)
          step_of = {`FSBL_K_WR, `FSBL_C_READ_STATUS};
        else if (idx == 2'h1)
          step_of = {`FSBL_K_RD, 8'h00};
      end
      fsbl_pkg::OP_CLEAR_STATUS:
      begin
        if (idx == 2'h0)
          step_of = {`FSBL_K_WR, `FSBL_C_CLEAR_STATUS};
      end
      fsbl_pkg::OP_RAW:
      begin
        if (idx == 2'h0)
          step_of = {`FSBL_K_WR, raw};
      end
      default: step_of = {`FSBL_K_END, 8'h00};
    endcase
  endfunction : step_of

  // software-visible state
  fsbl_pkg::fsbl_op_t op_q;
  logic [`FSBL_AW-1:0] addr_q;
  logic [1:0] ctrl_q;
  logic [7:0] raw_q;
  logic [7:0] stat_q;
  logic [1:0] lockbits_q;

  // sequencer state
  fsbl_pkg::fsbl_state_t st_q;
  logic [1:0] idx_q;
  logic [3:0] cnt_q;
  logic rd_lock_q;

  // apb decode
  wire apb_acc = i_psel & i_penable;
  wire hit_cmd = (i_paddr == `FSBL_REG_CMD);
  wire hit_addr = (i_paddr == `FSBL_REG_ADDR);
  wire hit_ctrl = (i_paddr == `FSBL_REG_CTRL);
  wire hit_stat = (i_paddr == `FSBL_REG_STAT);
  wire hit_data = (i_paddr == `FSBL_REG_DATA);
  wire hit_any = hit_cmd | hit_addr | hit_ctrl | hit_stat | hit_data;
  wire busy = (st_q != fsbl_pkg::ST_IDLE);
  // command, address and data writes during a sequence would corrupt the pins; refuse them
  wire wr_bad = i_pwrite & busy & (hit_cmd | hit_addr | hit_data);
  wire wr_bad_op = i_pwrite & hit_cmd & (i_pwdata[2:0] > 3'(fsbl_pkg::OP_RAW));
  wire start = apb_acc & i_pwrite & hit_cmd & ~busy & ~wr_bad_op;

  // error view, only meaningful once the engine reports ready
  wire ready = stat_q[`FSBL_SW_READY];
  wire e_seq = ready & stat_q[`FSBL_SW_PFAIL] & stat_q[`FSBL_SW_EFAIL];
  wire e_prog = ready & stat_q[`FSBL_SW_PFAIL] & ~stat_q[`FSBL_SW_EFAIL];
  wire e_erase = ready & stat_q[`FSBL_SW_EFAIL] & ~stat_q[`FSBL_SW_PFAIL];
  wire e_supply = ready & stat_q[`FSBL_SW_SUPPLY];
  wire e_lock = ready & stat_q[`FSBL_SW_LOCKED];
  wire paused = ready & (stat_q[`FSBL_SW_EPAUSE] | stat_q[`FSBL_SW_PPAUSE]);
  wire [31:0] stat_word = {14'h0000, lockbits_q, 2'h0, paused, e_lock, e_supply,
                           e_erase, e_prog, e_seq, stat_q[7:1], busy};

  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc & (~hit_any | (i_pwrite & hit_stat) | wr_bad | wr_bad_op);
  assign o_prdata = hit_cmd ? {29'h0, op_q} :
                    hit_addr ? {10'h000, addr_q} :
                    hit_ctrl ? {30'h0, ctrl_q} :
                    hit_stat ? stat_word :
                    hit_data ? {24'h000000, raw_q} : 32'h00000000;

  // wp level goes straight to the pin; high lets locked-down blocks change
  assign o_fl_wp = ctrl_q[`FSBL_CTRL_WP];

  // software registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      op_q <= fsbl_pkg::OP_READ_STATUS;
      addr_q <= '0;
      ctrl_q <= 2'h0;
      raw_q <= 8'h00;
    end
    else if (apb_acc & i_pwrite & ~wr_bad & ~wr_bad_op)
    begin
      if (hit_cmd)
        op_q <= fsbl_pkg::fsbl_op_t'(i_pwdata[2:0]);
      if (hit_addr)
        addr_q <= i_pwdata[`FSBL_AW-1:0];
      if (hit_ctrl)
        ctrl_q <= i_pwdata[1:0];
      if (hit_data)
        raw_q <= i_pwdata[7:0];
    end
  end

  // current step and the address it uses
  wire [9:0] cur_step = step_of(op_q, idx_q, raw_q);
  wire [1:0] cur_kind = cur_step[9:8];
  wire [`FSBL_AW-1:0] rd_addr = (op_q == fsbl_pkg::OP_READ_LOCK) ?
                                addr_q + `FSBL_LOCK_OFS : addr_q;
  wire cnt_done = (cnt_q == 4'h1);
  wire poll_again = ctrl_q[`FSBL_CTRL_POLL] & ~rd_lock_q &
                    ~stat_q[`FSBL_SW_READY];

  // flash bus sequencer; pins are registered so they change on clean edges
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= fsbl_pkg::ST_IDLE;
      idx_q <= 2'h0;
      cnt_q <= 4'h0;
      rd_lock_q <= 1'b0;
      stat_q <= 8'h00;
      lockbits_q <= 2'h0;
      o_fl_addr <= '0;
      o_fl_dq <= '0;
      o_fl_dq_oe_n <= 1'b1;
      o_fl_ce_n <= 1'b1;
      o_fl_we_n <= 1'b1;
      o_fl_oe_n <= 1'b1;
    end
    else
    begin
      case (st_q)
        fsbl_pkg::ST_IDLE:
        begin
          idx_q <= 2'h0;
          if (start)
            st_q <= fsbl_pkg::ST_FETCH;
        end
        fsbl_pkg::ST_FETCH:
        begin
          rd_lock_q <= (op_q == fsbl_pkg::OP_READ_LOCK);
          if (cur_kind == `FSBL_K_WR)
          begin
            o_fl_addr <= addr_q;
            o_fl_dq <= {8'h00, cur_step[7:0]};
            o_fl_dq_oe_n <= 1'b0;
            o_fl_ce_n <= 1'b0;
            st_q <= fsbl_pkg::ST_WR_SET;
          end
          else if (cur_kind == `FSBL_K_RD)
          begin
            o_fl_addr <= rd_addr;
            o_fl_dq_oe_n <= 1'b1;
            o_fl_ce_n <= 1'b0;
            o_fl_oe_n <= 1'b0;
            cnt_q <= 4'(`FSBL_RD_CYC);
            st_q <= fsbl_pkg::ST_RD_LOW;
          end
          else
            st_q <= fsbl_pkg::ST_IDLE;
        end
        fsbl_pkg::ST_WR_SET:
        begin
          o_fl_we_n <= 1'b0;
          cnt_q <= 4'(`FSBL_WE_CYC);
          st_q <= fsbl_pkg::ST_WR_LOW;
        end
        fsbl_pkg::ST_WR_LOW:
        begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_done)
          begin
            // data is latched on the rising write strobe; held one more cycle
            o_fl_we_n <= 1'b1;
            st_q <= fsbl_pkg::ST_WR_HOLD;
          end
        end
        fsbl_pkg::ST_WR_HOLD:
        begin
          o_fl_ce_n <= 1'b1;
          o_fl_dq_oe_n <= 1'b1;
          idx_q <= idx_q + 2'h1;
          st_q <= fsbl_pkg::ST_FETCH;
        end
        fsbl_pkg::ST_RD_LOW:
        begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_done)
          begin
            if (rd_lock_q)
              lockbits_q <= i_fl_dq[1:0];
            else
              stat_q <= i_fl_dq[7:0] & `FSBL_SW_MASK;
            o_fl_oe_n <= 1'b1;
            o_fl_ce_n <= 1'b1;
            st_q <= fsbl_pkg::ST_RD_END;
          end
        end
        fsbl_pkg::ST_RD_END:
        begin
          // a busy engine means the error bits are not final yet
          if (poll_again)
          begin
            o_fl_ce_n <= 1'b0;
            o_fl_oe_n <= 1'b0;
            cnt_q <= 4'(`FSBL_RD_CYC);
            st_q <= fsbl_pkg::ST_RD_LOW;
          end
          else if (&idx_q)
            st_q <= fsbl_pkg::ST_IDLE;         // fourth step done; index would wrap
          else
          begin
            idx_q <= idx_q + 2'h1;
            st_q <= fsbl_pkg::ST_FETCH;
          end
        end
        default: st_q <= fsbl_pkg::ST_IDLE;
      endcase
    end
  end

endmodule : fsbl_ctrl

// File: verification/fsbl_ctrl_asserts.sv
// pin and register-bus checks for the flash lock/status controller
// assumes a bind onto fsbl_ctrl, one clock domain
`timescale 1ns/100ps
`include "fsbl_defs.svh"
module fsbl_ctrl_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [`FSBL_AW-1:0] o_fl_addr,
  input wire logic [`FSBL_DW-1:0] o_fl_dq,
  input wire logic o_fl_dq_oe_n,
  input wire logic [`FSBL_DW-1:0] i_fl_dq,
  input wire logic o_fl_ce_n,
  input wire logic o_fl_we_n,
  input wire logic o_fl_oe_n,
  input wire logic o_fl_wp
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // bus decode, named so the properties stay short
  wire acc = i_psel && i_penable;
  wire stat_rd = acc && !i_pwrite && i_paddr == `FSBL_REG_STAT;
  wire wp_req = i_pwdata[`FSBL_CTRL_WP];
  // strobe widths: three cycles of write, four of read
  sequence we_low; !o_fl_we_n [*3] ##1 o_fl_we_n; endsequence
  sequence rd_low; !o_fl_oe_n [*4] ##1 o_fl_oe_n; endsequence
  we_width_a: assert property ($fell(o_fl_we_n) |-> we_low) else $error("write strobe width");
  rd_width_a: assert property ($fell(o_fl_oe_n) |-> rd_low) else $error("read window width");
  we_frame_a: assert property (!o_fl_we_n |-> !o_fl_ce_n && !o_fl_dq_oe_n && o_fl_oe_n)
    else $error("write strobe outside frame");
  we_setup_a: assert property ($fell(o_fl_we_n) |-> !$past(o_fl_ce_n) && !$past(o_fl_dq_oe_n))
    else $error("no setup before write strobe");
  we_hold_a: assert property ($rose(o_fl_we_n) |-> !o_fl_ce_n && $stable(o_fl_dq) && $stable(o_fl_addr))
    else $error("write data not held");
  cmd_byte_a: assert property (!o_fl_we_n |-> o_fl_dq[15:8] == 8'h00) else $error("upper byte set");
  rd_release_a: assert property (!o_fl_oe_n |-> o_fl_dq_oe_n && !o_fl_ce_n) else $error("read clash");
  stat_ro_a: assert property (acc && i_pwrite && i_paddr == `FSBL_REG_STAT |-> o_pslverr)
    else $error("status write accepted");
  unmapped_a: assert property (acc && i_paddr == 8'h14 |-> o_pslverr && o_prdata == 32'h00000000)
    else $error("unmapped access answered");
  wp_follow_a: assert property (acc && i_pwrite && i_paddr == `FSBL_REG_CTRL |=> o_fl_wp == $past(wp_req))
    else $error("protect pin not updated");
  seq_err_a: assert property (stat_rd && o_prdata[8] |-> o_prdata[7] && o_prdata[5] && o_prdata[4])
    else $error("sequence error flag inconsistent");
  ready_gate_a: assert property (stat_rd && o_prdata[13:8] != 6'h00 |-> o_prdata[7])
    else $error("error bits shown while busy");
endmodule : fsbl_ctrl_asserts

// File: verification/fsbl_flash_model.sv
// behavioural flash device: status word and per-block lock entries
// assumes commands latch on the write strobe rising edge; 4 blocks by addr[17:16]
`timescale 1ns/100ps
module fsbl_flash_model (
  input wire logic i_rst_n,        // power-up reset
  input wire logic i_ce_n,         // chip enable
  input wire logic i_we_n,         // write strobe
  input wire logic i_oe_n,         // output enable
  input wire logic i_wp,           // write-protect level
  input wire logic [21:0] i_addr,  // address
  input wire logic [15:0] i_dq,    // data from host
  input wire logic [3:0] i_slow,   // status reads answered busy
  input wire logic [2:0] i_fault,  // forced outcome: program, erase, supply
  output logic [15:0] o_dq         // data to host
);
  logic [3:0] lk, ld;
  logic [7:0] sr;
  logic setup;
  logic [1:0] mode;
  logic [3:0] wait_n;
  // pending program (1) or erase (2), and which kind ran last for suspend
  logic [1:0] arm;
  logic last_er;
  wire [1:0] blk = i_addr[17:16];
  wire id_rd = mode == 2'd1 && i_addr[15:0] == 16'h0002;
  // reserved bit driven high so a host that fails to mask it is caught
  wire [15:0] val = id_rd ? {14'h0, ld[blk], lk[blk]} : {8'h00, wait_n == 4'h0, sr[6:1], 1'b1};
  // released bus shows the inverse, never a stale copy
  assign o_dq = (!i_ce_n && !i_oe_n) ? val : ~val;
  // command decoder, lock changes act at once with no busy time
  always @(posedge i_we_n or negedge i_rst_n)
    if (!i_rst_n)
    begin
      lk <= 4'hF;
      ld <= 4'h0;
      sr <= 8'h80;
      setup <= 1'b0;
      mode <= 2'd0;
      wait_n <= 4'h0;
      arm <= 2'd0;
      last_er <= 1'b0;
    end
    else if (!i_ce_n)
    begin
      wait_n <= i_slow;
      setup <= !setup && arm == 2'd0 && i_dq[7:0] == 8'h60;
      arm <= 2'd0;
      if (setup)
        case (i_dq[7:0])
          8'h01: lk[blk] <= 1'b1;
          8'hD0: if (!(ld[blk] && !i_wp)) lk[blk] <= 1'b0;
          8'h2F: {ld[blk], lk[blk]} <= 2'b11;
          default: sr[5:4] <= 2'b11;
        endcase
      else if (arm != 2'd0)
      begin
        // engine work ends at once; the first failing check wins
        if (arm == 2'd2 && i_dq[7:0] != 8'hD0)
          sr[5:4] <= 2'b11;
        else if (i_fault[2])
          sr[3] <= 1'b1;
        else if (lk[blk])
          sr[1] <= 1'b1;
        else if (arm == 2'd1 && i_fault[0])
          sr[4] <= 1'b1;
        else if (arm == 2'd2 && i_fault[1])
          sr[5] <= 1'b1;
      end
      else
        case (i_dq[7:0])
          8'h40, 8'h10:
          begin
            arm <= 2'd1;
            last_er <= 1'b0;
          end
          8'h20:
          begin
            arm <= 2'd2;
            last_er <= 1'b1;
          end
          8'hB0:
            if (last_er)
              sr[6] <= 1'b1;
            else
              sr[2] <= 1'b1;
          8'hD0: {sr[6], sr[2]} <= 2'b00;
          8'h90: mode <= 2'd1;
          8'hFF: mode <= 2'd2;
          8'h70: mode <= 2'd0;
          8'h50: sr <= 8'h80;
          default: ;
        endcase
    end
  // protect pin falling puts locked-down blocks back to locked
  always @(negedge i_wp)
    if (i_rst_n)
      lk <= lk | ld;
  // slow answers: count down busy status reads
  always @(posedge i_oe_n)
    if (wait_n != 4'h0 && mode == 2'd0)
      wait_n <= wait_n - 4'h1;
endmodule : fsbl_flash_model

// File: verification/tb_top.sv
// self-checking bench: apb tasks drive the controller against the flash model
// assumes zero-wait apb and a 40 MHz clock
`timescale 1ns/100ps
`include "fsbl_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic i_sys_clk, i_rst_n, i_psel, i_penable, i_pwrite, perr;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rdata;
  logic o_pready, o_pslverr, o_fl_dq_oe_n, o_fl_ce_n, o_fl_we_n, o_fl_oe_n, o_fl_wp;
  logic [21:0] o_fl_addr;
  logic [15:0] o_fl_dq, i_fl_dq, dev_dq;
  logic [3:0] slow;
  logic [2:0] fault;
  int fails, n_tests, cyc;
  // shared dq wire: whoever enables drives it
  assign i_fl_dq = o_fl_dq_oe_n ? dev_dq : o_fl_dq;
  fsbl_ctrl fsbl_ctrl_i (.*);
  fsbl_flash_model fsbl_flash_model_i (.i_rst_n(i_rst_n), .i_ce_n(o_fl_ce_n),
    .i_we_n(o_fl_we_n), .i_oe_n(o_fl_oe_n), .i_wp(o_fl_wp), .i_addr(o_fl_addr),
    .i_dq(o_fl_dq), .i_slow(slow), .i_fault(fault), .o_dq(dev_dq));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic end_of_test;
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // hang guard, far above the roughly 1200 cycles the tests need
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rdata = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask : apb
  task automatic run(input logic [2:0] op);
    apb(1'b1, `FSBL_REG_CMD, {29'h0, op});
    do apb(1'b0, `FSBL_REG_STAT, 32'h0); while (rdata[0] !== 1'b0);
  endtask : run
  task automatic op_at(input logic [1:0] b, input logic [2:0] op);
    apb(1'b1, `FSBL_REG_ADDR, {14'h0, b, 16'h0});
    run(op);
  endtask : op_at
  task automatic lockbits(input logic [1:0] b, input logic [1:0] exp);
    op_at(b, 3'd3);
    `CHK(rdata[17:16], exp)
  endtask : lockbits
  task automatic raw(input logic [7:0] c);
    apb(1'b1, `FSBL_REG_DATA, {24'h000000, c});
    run(3'd6);
  endtask : raw
  // status flags [13:8] after a status read, then clear them
  task automatic flags(input logic [5:0] exp);
    run(3'd4);
    `CHK(rdata[13:8], exp)
    run(3'd5);
  endtask : flags
  initial
  begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, slow, fault} = '0;
    {fails, n_tests, cyc} = '0;
    i_rst_n = 1'b1;
    #1 i_rst_n = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, `FSBL_REG_CMD, 32'h0);
    `CHK(rdata, 32'h00000004)
    lockbits(2'd0, 2'b01);
    op_at(2'd1, 3'd1);
    lockbits(2'd1, 2'b00);
    // second command while busy is refused
    apb(1'b1, `FSBL_REG_CMD, 32'h0);
    apb(1'b1, `FSBL_REG_CMD, 32'h1);
    `CHK(perr, 1'b1)
    run(3'd4);
    lockbits(2'd1, 2'b01);
    op_at(2'd2, 3'd2);
    lockbits(2'd2, 2'b11);
    op_at(2'd2, 3'd1);
    lockbits(2'd2, 2'b11);
    apb(1'b1, `FSBL_REG_CTRL, 32'h1);
    op_at(2'd2, 3'd1);
    lockbits(2'd2, 2'b10);
    op_at(2'd2, 3'd0);
    lockbits(2'd2, 2'b11);
    op_at(2'd2, 3'd1);
    apb(1'b1, `FSBL_REG_CTRL, 32'h0);
    lockbits(2'd2, 2'b11);
    // bad code after lock setup through raw writes
    apb(1'b1, `FSBL_REG_DATA, 32'h60);
    run(3'd6);
    apb(1'b1, `FSBL_REG_DATA, 32'h00);
    run(3'd6);
    run(3'd4);
    `CHK(rdata[13:1], 13'h00D8)
    run(3'd5);
    run(3'd4);
    `CHK(rdata[13:1], 13'h0040)
    // slow device with polling on
    slow <= 4'd3;
    apb(1'b1, `FSBL_REG_CTRL, 32'h2);
    run(3'd4);
    `CHK(rdata[7], 1'b1)
    slow <= 4'd0;
    apb(1'b0, 8'h14, 32'h0);
    `CHK({perr, rdata}, {1'b1, 32'h0})
    apb(1'b1, `FSBL_REG_STAT, 32'h1);
    `CHK(perr, 1'b1)
    // program, erase and suspend outcomes as the far side reports them
    op_at(2'd0, 3'd1);
    fault <= 3'b001;
    raw(8'h40);
    raw(8'h55);
    flags(6'h02);
    fault <= 3'b010;
    raw(8'h20);
    raw(8'hD0);
    flags(6'h04);
    fault <= 3'b100;
    raw(8'h40);
    raw(8'h55);
    flags(6'h08);
    fault <= 3'b000;
    raw(8'h40);
    raw(8'h55);
    flags(6'h00);
    raw(8'h40);
    raw(8'h55);
    raw(8'hB0);
    flags(6'h20);
    raw(8'h20);
    raw(8'hD0);
    raw(8'hB0);
    flags(6'h20);
    raw(8'hB0);
    raw(8'hD0);
    flags(6'h00);
    apb(1'b1, `FSBL_REG_ADDR, {14'h0, 2'd1, 16'h0});
    raw(8'h40);
    raw(8'h55);
    flags(6'h10);
    // reset after a finished lock-down drops it
    op_at(2'd3, 3'd2);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    lockbits(2'd3, 2'b01);
    end_of_test();
  end
endmodule : tb_top
bind fsbl_ctrl fsbl_ctrl_asserts fsbl_ctrl_asserts_i (.*);
